// ---- dtu_pins.sv ----
// Purpose: pin side partner of the timer unit
// Assumes: the bench sets the wanted levels
// Notes: levels move only just after a rising edge
`timescale 1ns/100ps
module dtu_pins (
	input wire logic pclk,
	input wire logic [6:0] want,
	output logic [6:0] pins
);
	always_ff @(posedge pclk) begin
		pins <= want;
	end
endmodule

// ---- dtu_pkg.sv ----
// Purpose: constants and types of the dual timer unit
// Assumes: apb slave, 32-bit data, one aligned word per register
// Notes: offsets are byte addresses
// Notes on behaviour
// - fastest prescale advances a timer once every 2 system clocks.
// - exactly two timers, auxiliary and core, plus one capture/reload register.
// - each timer counts prescaled system clock or external pin edges.
// - direction from software bit, or from the direction pin level.
// - core timer inverts its toggle latch on each overflow or underflow.
// - auxiliary timer may count on core toggle latch changes.
// - toggle latch may be driven onto its own output pin.
// - core overflow or underflow gives a count pulse to the neighbour unit.
// - core overflow or underflow may reload from the capture/reload register.
// - capture pin edge copies auxiliary count into capture/reload register.
// - optional clear of auxiliary timer right after each capture.
// - capture may also trigger from companion count or direction inputs.
package dtu_pkg;
	localparam logic [7:0] DTU_AUX_CTRL = 8'h00;
	localparam logic [7:0] DTU_CORE_CTRL = 8'h04;
	localparam logic [7:0] DTU_AUX_CNT = 8'h08;
	localparam logic [7:0] DTU_CORE_CNT = 8'h0C;
	localparam logic [7:0] DTU_CAPTURE_RELOAD_REGISTER = 8'h10;
	localparam logic [7:0] DTU_CAP_CTRL = 8'h14;
	localparam logic [7:0] DTU_IRQ_STAT = 8'h18;
	localparam logic [7:0] DTU_IRQ_EN = 8'h1C;
	localparam logic [7:0] DTU_IRQ_CLR = 8'h20;
	// timer control fields
	localparam int DTU_T_RUN = 0;
	localparam int DTU_T_DOWN = 1;
	localparam int DTU_T_PINDIR = 2;
	localparam int DTU_T_SRC_LO = 3; // 2 bits: 0 prescaled, 1 pin, 2 latch
	localparam int DTU_T_PRE_LO = 5; // 3 bits: divide 2 << pre
	localparam int DTU_T_RELOAD = 8;
	localparam int DTU_T_PINOUT = 9;
	// capture control fields
	localparam int DTU_C_EDGE_LO = 0; // 2 bits: 0 off,1 rise,2 fall,3 both
	localparam int DTU_C_SRC_LO = 2;  // 2 bits: pin, count in, dir in, both
	localparam int DTU_C_CLEAR = 4;
	// status bits
	localparam int DTU_S_AUX = 0;
	localparam int DTU_S_CORE = 1;
	localparam int DTU_S_CAP = 2;
	localparam int DTU_PRE_BASE = 2;
	localparam logic [1:0] DTU_SRC_PRE = 2'h0;
	localparam logic [1:0] DTU_SRC_PIN = 2'h1;
	localparam logic [1:0] DTU_SRC_LATCH = 2'h2;
	localparam logic [15:0] DTU_CNT_RST = 16'h0000;
endpackage

// ---- dtu_properties.sv ----
// Purpose: port checks of the timer unit
// Assumes: zero-wait apb slave
// Notes: bound below
`timescale 1ns/100ps
module dtu_properties import dtu_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic toggle_latch_pin,
	input wire logic neighbour_count_pulse,
	input wire logic irq
);
	logic rd_setup;
	wire logic wr_go = psel && penable && pwrite;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rd_setup <= 1'b0;
		else
			rd_setup <= psel && !penable && !pwrite;
	end
	chk_pulse_single: assert property (
		neighbour_count_pulse |=> !neighbour_count_pulse) else $error("pulse");
	chk_latch_pace: assert property (
		$changed(toggle_latch_pin) |=> $stable(toggle_latch_pin))
		else $error("latch pace");
	chk_pin_off: assert property (
		wr_go && paddr == DTU_CORE_CTRL && !pwdata[DTU_T_PINOUT]
		|-> ##[1:2] !toggle_latch_pin) else $error("pin on");
	chk_irq_masked: assert property (
		wr_go && paddr == DTU_IRQ_EN && pwdata[2:0] == 3'h0 |-> ##2 !irq)
		else $error("irq masked");
	chk_rdata_hold: assert property (
		$changed(prdata) |-> rd_setup) else $error("read data moved");
	chk_read_unmapped: assert property (
		psel && !penable && !pwrite && paddr > DTU_IRQ_CLR
		|=> prdata == 32'h0) else $error("unmapped read");
	chk_zero_wait: assert property (
		psel && penable |-> pready && !pslverr) else $error("apb stall");
	chk_reset_quiet: assert property (
		$rose(presetn) |-> !irq && !neighbour_count_pulse
		&& !toggle_latch_pin) else $error("reset outputs");
endmodule

bind dtu_top dtu_properties u_props (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.toggle_latch_pin, .neighbour_count_pulse, .irq);

// ---- dtu_top.sv ----
// Purpose: dual timer unit with capture/reload register on apb
// Assumes: pins are asynchronous and pass two flip-flops first
// Notes: no wait states; unmapped reads give zero, pslverr low
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/100ps
module dtu_top #(
	parameter int CNT_W = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic aux_count_pin,
	input wire logic core_count_pin,
	input wire logic aux_direction_input_pin,
	input wire logic core_direction_input_pin,
	input wire logic capture_input_pin,
	input wire logic companion_count_input,
	input wire logic companion_direction_input,
	output logic toggle_latch_pin,
	output logic neighbour_count_pulse,
	output logic irq
);
	import dtu_pkg::*;

	initial begin
		if (CNT_W < 2 || CNT_W > 32) begin
			$error("dtu_top: CNT_W out of range");
		end
	end

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	// two timers and one shared capture/reload register
	typedef struct packed {
		// control words as software wrote them
		logic [9:0] aux_ctrl;
		logic [9:0] core_ctrl;
		logic [4:0] cap_ctrl;
		// counters and the shared capture/reload register
		logic [CNT_W-1:0] aux_cnt;
		logic [CNT_W-1:0] core_cnt;
		logic [CNT_W-1:0] capture_reload_register;
		// free-running prescaler counts
		logic [8:0] aux_pre;
		logic [8:0] core_pre;
		// toggle latch and its copy one clock later
		logic core_latch;
		logic latch_seen;
		// sticky status, enable mask, count pulse
		logic [2:0] stat;
		logic [2:0] en;
		logic pulse;
		// pin stages: aux cnt, core cnt, aux dir, core dir, capture
		logic [4:0] s1;
		logic [4:0] s2;
		logic [4:0] s3;
		// companion stages: count input bit 0, direction input bit 1
		logic [1:0] cs1;
		logic [1:0] cs2;
		logic [1:0] cs3;
		// read data, held until the next read setup
		logic [31:0] rdata;
	} dtu_state_t;

	dtu_state_t st;
	dtu_state_t nx;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// true on the edges that the mode selects; mode 0 never fires
	function automatic logic edge_hit(input logic [1:0] mode,
		input logic now, input logic old);
		edge_hit = (mode[0] && now && !old) || (mode[1] && !now && old);
	endfunction

	// limit is (2 << sel) - 1, so the fastest rate is every 2nd clock
	function automatic logic pre_tick(input logic [8:0] cnt,
		input logic [2:0] sel);
		logic [8:0] lim;
		lim = 9'((DTU_PRE_BASE << sel) - 1);
		pre_tick = (cnt >= lim);
	endfunction

	// next prescaler count; back to zero on its own tick
	function automatic logic [8:0] pre_next(input logic [8:0] cnt,
		input logic [2:0] sel);
		if (pre_tick(cnt, sel)) begin
			pre_next = 9'h000;
		end else begin
			pre_next = 9'(cnt + 9'h001);
		end
	endfunction

	// one count step in the chosen direction, wrapping at either end
	function automatic logic [CNT_W-1:0] cnt_step(
		input logic [CNT_W-1:0] cnt, input logic dn);
		if (dn) begin
			cnt_step = CNT_W'(cnt - 1'b1);
		end else begin
			cnt_step = CNT_W'(cnt + 1'b1);
		end
	endfunction

	// true when the next step leaves the count range
	function automatic logic cnt_end(input logic [CNT_W-1:0] cnt,
		input logic dn);
		logic [CNT_W-1:0] top;
		top = '1;
		if (dn) begin
			cnt_end = (cnt == '0);
		end else begin
			cnt_end = (cnt == top);
		end
	endfunction

	// the pin level wins over the software bit when selected
	function automatic logic dir_down(input logic [9:0] ctrl,
		input logic pin_lvl);
		if (ctrl[DTU_T_PINDIR]) begin
			dir_down = pin_lvl;
		end else begin
			dir_down = ctrl[DTU_T_DOWN];
		end
	endfunction

	// rising edge of a synchronised pin
	function automatic logic pin_rise(input logic now, input logic old);
		pin_rise = now && !old;
	endfunction

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	logic wr;
	logic rd;
	logic aux_tick;
	logic core_tick;
	logic aux_dn;
	logic core_dn;
	logic core_wrap;
	logic aux_wrap;
	logic cap_trig;

	always_comb begin
		nx = st;
		wr = psel && penable && pwrite;
		rd = psel && !penable && !pwrite;

		// ------------------------------------------------------------
		// pin synchronisers
		// ------------------------------------------------------------
		// logic reads only the second stage; the third one only keeps
		// the old level so that edges can be seen
		nx.s1 = {capture_input_pin, core_direction_input_pin,
			aux_direction_input_pin, core_count_pin, aux_count_pin};
		nx.s2 = st.s1;
		nx.s3 = st.s2;
		nx.cs1 = {companion_direction_input, companion_count_input};
		nx.cs2 = st.cs1;
		nx.cs3 = st.cs2;

		// ------------------------------------------------------------
		// prescalers and count sources
		// ------------------------------------------------------------
		// prescalers run freely, smallest divide is 2
		nx.aux_pre = pre_next(st.aux_pre,
			st.aux_ctrl[DTU_T_PRE_LO +: 3]);
		nx.core_pre = pre_next(st.core_pre,
			st.core_ctrl[DTU_T_PRE_LO +: 3]);
		// the latch source is meaningless for the core timer: no tick
		unique case (st.core_ctrl[DTU_T_SRC_LO +: 2])
			DTU_SRC_PIN: core_tick = pin_rise(st.s2[1], st.s3[1]);
			DTU_SRC_PRE: core_tick = pre_tick(st.core_pre,
				st.core_ctrl[DTU_T_PRE_LO +: 3]);
			default: core_tick = 1'b0;
		endcase
		core_tick = core_tick && st.core_ctrl[DTU_T_RUN];
		unique case (st.aux_ctrl[DTU_T_SRC_LO +: 2])
			DTU_SRC_PIN: aux_tick = pin_rise(st.s2[0], st.s3[0]);
			DTU_SRC_LATCH: aux_tick = st.core_latch != st.latch_seen;
			DTU_SRC_PRE: aux_tick = pre_tick(st.aux_pre,
				st.aux_ctrl[DTU_T_PRE_LO +: 3]);
			default: aux_tick = 1'b0;
		endcase
		aux_tick = aux_tick && st.aux_ctrl[DTU_T_RUN];
		core_dn = dir_down(st.core_ctrl, st.s2[3]);
		aux_dn = dir_down(st.aux_ctrl, st.s2[2]);

		// ------------------------------------------------------------
		// core timer, toggle latch and count pulse
		// ------------------------------------------------------------
		core_wrap = core_tick && cnt_end(st.core_cnt, core_dn);
		nx.pulse = core_wrap;
		if (core_wrap) begin
			nx.core_latch = !st.core_latch;
		end
		nx.latch_seen = st.core_latch;
		if (core_tick) begin
			if (core_wrap && st.core_ctrl[DTU_T_RELOAD]) begin
				nx.core_cnt = st.capture_reload_register;
			end else begin
				nx.core_cnt = cnt_step(st.core_cnt, core_dn);
			end
		end

		// ------------------------------------------------------------
		// auxiliary timer
		// ------------------------------------------------------------
		aux_wrap = aux_tick && cnt_end(st.aux_cnt, aux_dn);
		if (aux_tick) begin
			nx.aux_cnt = cnt_step(st.aux_cnt, aux_dn);
		end

		// ------------------------------------------------------------
		// capture
		// ------------------------------------------------------------
		// capture trigger, none when edge mode is off
		unique case (st.cap_ctrl[DTU_C_SRC_LO +: 2])
			2'h0: cap_trig = edge_hit(st.cap_ctrl[DTU_C_EDGE_LO +: 2],
				st.s2[4], st.s3[4]);
			2'h1: cap_trig = edge_hit(st.cap_ctrl[DTU_C_EDGE_LO +: 2],
				st.cs2[0], st.cs3[0]);
			2'h2: cap_trig = edge_hit(st.cap_ctrl[DTU_C_EDGE_LO +: 2],
				st.cs2[1], st.cs3[1]);
			default: cap_trig =
				edge_hit(st.cap_ctrl[DTU_C_EDGE_LO +: 2],
				st.cs2[0], st.cs3[0]) ||
				edge_hit(st.cap_ctrl[DTU_C_EDGE_LO +: 2],
				st.cs2[1], st.cs3[1]);
		endcase
		if (cap_trig) begin
			nx.capture_reload_register = st.aux_cnt;
			// the clear wins over a count step in the same clock
			if (st.cap_ctrl[DTU_C_CLEAR]) begin
				nx.aux_cnt = '0;
			end
		end

		// ------------------------------------------------------------
		// register writes
		// ------------------------------------------------------------
		// a software write wins over the hardware update of that clock, except that status flags set below win over an irq clear
		if (wr) begin
			unique case (paddr)
				DTU_AUX_CTRL: nx.aux_ctrl = pwdata[9:0];
				DTU_CORE_CTRL: nx.core_ctrl = pwdata[9:0];
				DTU_AUX_CNT: nx.aux_cnt = pwdata[CNT_W-1:0];
				DTU_CORE_CNT: nx.core_cnt = pwdata[CNT_W-1:0];
				DTU_CAPTURE_RELOAD_REGISTER: nx.capture_reload_register = pwdata[CNT_W-1:0];
				DTU_CAP_CTRL: nx.cap_ctrl = pwdata[4:0];
				DTU_IRQ_EN: nx.en = pwdata[2:0];
				DTU_IRQ_CLR: nx.stat = st.stat & ~pwdata[2:0];
				default: ;
			endcase
		end

		// ------------------------------------------------------------
		// sticky flags
		// ------------------------------------------------------------
		// set after the clear, so an event in the clear's clock is kept
		if (aux_wrap) begin
			nx.stat[DTU_S_AUX] = 1'b1;
		end
		if (core_wrap) begin
			nx.stat[DTU_S_CORE] = 1'b1;
		end
		if (cap_trig) begin
			nx.stat[DTU_S_CAP] = 1'b1;
		end

		// ------------------------------------------------------------
		// read data
		// ------------------------------------------------------------
		// taken in the setup clock so the access phase needs no wait
		if (rd) begin
			unique case (paddr)
				DTU_AUX_CTRL: nx.rdata = 32'(st.aux_ctrl);
				DTU_CORE_CTRL: nx.rdata = 32'(st.core_ctrl);
				DTU_AUX_CNT: nx.rdata = 32'(st.aux_cnt);
				DTU_CORE_CNT: nx.rdata = 32'(st.core_cnt);
				DTU_CAPTURE_RELOAD_REGISTER: nx.rdata = 32'(st.capture_reload_register);
				DTU_CAP_CTRL: nx.rdata = 32'(st.cap_ctrl);
				DTU_IRQ_STAT: nx.rdata = 32'(st.stat);
				DTU_IRQ_EN: nx.rdata = 32'(st.en);
				default: nx.rdata = 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else begin
			st <= nx;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// the bus never stalls and never reports an error
	assign prdata = st.rdata;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	// the latch runs on whether or not it reaches the pin
	assign toggle_latch_pin = st.core_latch &&
		st.core_ctrl[DTU_T_PINOUT];
	assign neighbour_count_pulse = st.pulse;
	assign irq = |(st.stat & st.en);
endmodule

// ---- dual_timer_capture_reload_tb.sv ----
// Purpose: self-checking bench of the timer unit
// Assumes: zero-wait apb
// Notes: rows, then wrap, rate, capture and pin cases
`timescale 1ns/100ps
module dual_timer_capture_reload_tb;
	import dtu_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, pready, pslverr, toggle_latch_pin, irq;
	logic neighbour_count_pulse;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [6:0] want = 7'h00, pins;
	int bad_count = 0, samples_checked = 0, n;
	logic [71:0] rows [8] = '{{DTU_CORE_CTRL, 32'h300, 32'h300},
		{DTU_AUX_CNT, 32'h1234, 32'h1234}, {DTU_CAPTURE_RELOAD_REGISTER, 32'h5, 32'h5},
		{DTU_CAP_CTRL, 32'h11, 32'h11}, {DTU_IRQ_EN, 32'h7, 32'h7},
		{DTU_IRQ_STAT, 32'h7, 32'h0}, {8'h24, 32'h5A, 32'h0},
		{DTU_CORE_CNT, 32'hFFFE, 32'hFFFE}};
	always #25 pclk = ~pclk;
	dtu_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .aux_count_pin(pins[0]),
		.core_count_pin(pins[1]), .aux_direction_input_pin(pins[2]),
		.core_direction_input_pin(pins[3]), .capture_input_pin(pins[4]),
		.companion_count_input(pins[5]),
		.companion_direction_input(pins[6]), .toggle_latch_pin,
		.neighbour_count_pulse, .irq);
	dtu_pins u_pins (.pclk, .want, .pins);
	task automatic give_verdict();
		if (bad_count == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic hang();
		bad_count++;
		give_verdict();
	endtask
	task automatic check(input string s, input logic [31:0] e, got);
		samples_checked++;
		if (got !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", s, e, got);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		{psel, penable} <= 2'b00;
		if (n == 50) hang();
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check("reg", e, rd);
	endtask
	task automatic pin(input int i, input logic v);
		@(posedge pclk);
		want[i] <= v;
		// pins cross two sync flops, so leave the edge time to act
		repeat (6) @(posedge pclk);
	endtask
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i]) begin
			apb(1'b1, rows[i][71:64], rows[i][63:32]);
			rchk(rows[i][71:64], rows[i][31:0]);
		end
		apb(1'b1, DTU_CORE_CTRL, 32'h301);
		for (n = 0; neighbour_count_pulse !== 1'b1; n++) begin
			@(negedge pclk);
			if (n == 50) hang();
		end
		apb(1'b1, DTU_CORE_CTRL, 32'h300);
		apb(1'b0, DTU_CORE_CNT, 32'h0);
		check("reload", 32'h1, {31'h0, rd > 4 && rd < 9});
		check("latch", 32'h3, {30'h0, toggle_latch_pin, irq});
		rchk(DTU_IRQ_STAT, 32'h2);
		apb(1'b1, DTU_IRQ_CLR, 32'h7);
		rchk(DTU_IRQ_STAT, 32'h0);
		apb(1'b1, DTU_CORE_CNT, 32'h0);
		apb(1'b1, DTU_CORE_CTRL, 32'h001);
		repeat (40) @(posedge pclk);
		apb(1'b1, DTU_CORE_CTRL, 32'h000);
		apb(1'b0, DTU_CORE_CNT, 32'h0);
		check("rate", 32'h1, {31'h0, rd > 19 && rd < 24});
		pin(4, 1'b1);
		rchk(DTU_CAPTURE_RELOAD_REGISTER, 32'h1234);
		rchk(DTU_AUX_CNT, 32'h0);
		apb(1'b1, DTU_AUX_CNT, 32'h200);
		pin(4, 1'b0);
		rchk(DTU_CAPTURE_RELOAD_REGISTER, 32'h1234);
		apb(1'b1, DTU_CAP_CTRL, 32'h07);
		pin(5, 1'b1);
		rchk(DTU_CAPTURE_RELOAD_REGISTER, 32'h200);
		apb(1'b1, DTU_AUX_CTRL, 32'h0D);
		pin(2, 1'b1);
		repeat (3) begin
			pin(0, 1'b1);
			pin(0, 1'b0);
		end
		rchk(DTU_AUX_CNT, 32'h1FD);
		apb(1'b1, DTU_CAP_CTRL, 32'h0B);
		pin(6, 1'b1);
		rchk(DTU_CAPTURE_RELOAD_REGISTER, 32'h1FD);
		apb(1'b1, DTU_AUX_CTRL, 32'h11);
		apb(1'b1, DTU_CORE_CNT, 32'hFFFF);
		apb(1'b1, DTU_CORE_CTRL, 32'h001);
		repeat (6) @(posedge pclk);
		apb(1'b1, DTU_CORE_CTRL, 32'h000);
		rchk(DTU_AUX_CNT, 32'h1FE);
		apb(1'b1, DTU_IRQ_EN, 32'h0);
		@(negedge pclk);
		check("irq", 32'h0, {31'h0, irq});
		give_verdict();
	end
endmodule
